/* hw/ds3_rx_alarm_pkg.sv */
// Constants, register map and state types for the receive alarm detector.
// Assumes a byte-addressed register bus with one 32-bit word per register.
package ds3_rx_alarm_pkg;

	// Register bus geometry
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CFG_STATUS  = 8'h10;
	localparam logic [7:0] IDX_LINE_STATUS = 8'h11;
	localparam logic [7:0] IDX_INT_FLAGS   = 8'h13;
	localparam logic [7:0] IDX_CONTROL     = 8'h20;
	localparam logic [7:0] IDX_FEBE_MSB    = 8'h58;
	localparam logic [7:0] IDX_FEBE_LSB    = 8'h59;

	// Configuration and alarm status fields
	localparam int CFG_AIS_BIT  = 7;
	localparam int CFG_IDLE_BIT = 5;
	localparam int CFG_OPT_LSB  = 0;
	localparam int CFG_OPT_W    = 3;

	// Line status fields
	localparam int LINE_YELLOW_BIT = 4;
	localparam int LINE_AIC_BIT    = 3;
	localparam int LINE_FEBE_LSB   = 0;

	// Interrupt flag fields
	localparam int INT_AIS_BIT  = 5;
	localparam int INT_IDLE_BIT = 4;
	localparam int INT_FERF_BIT = 3;
	localparam int INT_AIC_BIT  = 2;

	// Control fields
	localparam int CTRL_AUTO_FERF_BIT = 0;

	// Reset values
	localparam logic [2:0] CFG_OPT_RESET        = 3'h0;
	localparam logic       CTRL_AUTO_FERF_RESET = 1'b1;

	// Alarm counters
	localparam int         COUNT_W      = 6;
	localparam logic [5:0] ALARM_THRESH = 6'h3F;

	// Overhead encodings
	localparam logic [2:0]  FEBE_CLEAN   = 3'h7;
	localparam logic [2:0]  FEBE_ERRORED = 3'h0;
	localparam logic [1:0]  X_BITS_SET   = 2'h3;
	localparam logic [1:0]  X_BITS_CLEAR = 2'h0;
	localparam logic [15:0] FEBE_MAX     = 16'hFFFF;

	// Registered state of the top module, apart from its two alarm counters
	typedef struct packed {
		logic [2:0]  cfgOpt;
		logic        autoFerf;
		logic        yellow;
		logic        aic;
		logic [2:0]  febeRx;
		logic        intAis;
		logic        intIdle;
		logic        intFerf;
		logic        intAic;
		logic [15:0] febeCount;
		logic [7:0]  febeLsbHold;
		logic        aisPin;
		logic        txFerf;
		logic [2:0]  txFebe;
		logic        intReq;
		logic        waitReq;
		logic [31:0] rdData;
	} rx_state_t;

endpackage

/* hw/alarm_count_if.sv */
// Link between the top module and one up/down alarm counter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface alarm_count_if;
	logic                                 frameTick;
	logic                                 hit;
	logic                                 declared;
	logic                                 changed;
	logic [ds3_rx_alarm_pkg::COUNT_W-1:0] count;

	modport counter (
		input  frameTick,
		input  hit,
		output declared,
		output changed,
		output count
	);

	modport user (
		output frameTick,
		output hit,
		input  declared,
		input  changed,
		input  count
	);
endinterface

/* hw/alarm_updown_counter.sv */
// Saturating up/down M-frame counter with declare and clear hysteresis.
// Assumes frameTick pulses once per M-frame on the same clock.
`timescale 1ns/100ps
module alarm_updown_counter #(
	parameter logic [ds3_rx_alarm_pkg::COUNT_W-1:0] THRESH = ds3_rx_alarm_pkg::ALARM_THRESH
) (
	input wire logic      clk,
	input wire logic      sys_rst,
	alarm_count_if.counter cnt
);
	localparam int W = ds3_rx_alarm_pkg::COUNT_W;
	localparam logic [W-1:0] MAXC = {W{1'b1}};

	typedef struct packed {
		logic [W-1:0] count;
		logic         declared;
		logic         changed;
	} cnt_state_t;

	cnt_state_t st_ff;
	cnt_state_t nxt_st;

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.changed = 1'b0;
		if (cnt.frameTick)
		begin
			if (cnt.hit)
			begin
				if (st_ff.count != MAXC)
					nxt_st.count = st_ff.count + 1'b1;
			end
			else if (st_ff.count != '0)
				nxt_st.count = st_ff.count - 1'b1;
		end
		if (!st_ff.declared && nxt_st.count >= THRESH)
		begin
			nxt_st.declared = 1'b1;
			nxt_st.changed = 1'b1;
		end
		else if (st_ff.declared && nxt_st.count == '0)
		begin
			nxt_st.declared = 1'b0;
			nxt_st.changed = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign cnt.declared = st_ff.declared;
	assign cnt.changed  = st_ff.changed;
	assign cnt.count    = st_ff.count;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	declare_at_thresh_a: assert property ($rose(st_ff.declared) |-> st_ff.count >= THRESH)
		else $error("alarm declared below threshold");
	clear_at_zero_a: assert property ($fell(st_ff.declared) |-> st_ff.count == '0)
		else $error("alarm cleared with nonzero count");
	count_floor_a: assert property (cnt.frameTick && !cnt.hit && st_ff.count == '0 |=> st_ff.count == '0)
		else $error("counter went below zero");
	count_step_a: assert property (cnt.frameTick && cnt.hit && st_ff.count != MAXC
		|=> st_ff.count == $past(st_ff.count) + 1'b1)
		else $error("counter missed an increment");
endmodule

/* hw/ds3_rx_alarm_detector.sv */
// Receive DS3 alarm detector: AIS, idle, yellow, AIC and far-end block errors.
// Assumes per-M-frame overhead results from the receive framer on clk,
// and an Avalon-MM master for the register bus.
`timescale 1ns/100ps
// Contract
// - AIS frame needs valid overhead, zero C, 1010
// - AIS counter from zero, up/down, floors at zero
// - Declare AIS at count 63 or more
// - AIS drives pin and status bit 7
// - Interrupt on AIS declare and clear
// - AIS forces transmit of far-end failure
// - Clear AIS when counter returns to zero
// - Idle frame needs valid overhead, CP zero, 1100
// - Idle counter floors at zero, declares at 63
// - Interrupt on any idle status change
// - Clear idle when counter returns to zero
// - X bits zero declare yellow, status bit 4
// - Yellow change sets flag and interrupt
// - X bits one clear yellow alarm
// - FEBE not 111 increments event counter
// - Transmit FEBE 111 only without parity errors
// - AIC bit: one C-bit parity, zero M13
// - Latest AIC bit shown in status bit 3
// - AIC change sets interrupt flag bit 2
module ds3_rx_alarm_detector (
	input  wire logic                                  clk,
	input  wire logic                                  sys_rst,
	input  wire logic                                  frameDone,
	input  wire logic                                  framingValid,
	input  wire logic                                  cBitsZero,
	input  wire logic                                  cpBitsZero,
	input  wire logic [1:0]                            xBits,
	input  wire logic                                  payloadAlternating,
	input  wire logic                                  payloadPairs,
	input  wire logic [2:0]                            rx_far_block_error_bits,
	input  wire logic                                  rx_app_ident_bit,
	input  wire logic                                  parityErr,
	input  wire logic                                  cpParityErr,
	input  wire logic [ds3_rx_alarm_pkg::ADDR_W-1:0]   address,
	input  wire logic                                  read,
	input  wire logic                                  write,
	input  wire logic [ds3_rx_alarm_pkg::DATA_W-1:0]   writedata,
	input  wire logic [3:0]                            byteenable,
	output logic      [ds3_rx_alarm_pkg::DATA_W-1:0]   readdata,
	output logic                                       waitrequest,
	output logic                                       rx_alarm_indication_flag,
	output logic                                       txFerfRequest,
	output logic      [2:0]                            txFebeBits,
	output logic                                       intRequest
);
	ds3_rx_alarm_pkg::rx_state_t st_ff;
	ds3_rx_alarm_pkg::rx_state_t nxt_st;

	alarm_count_if aisIf ();
	alarm_count_if idleIf ();

	logic       aisFrame;
	logic       idleFrame;
	logic       busCap;
	logic [7:0] regIdx;
	logic       capIntRead;
	logic       capFebeRead;
	logic       yellowNext;
	logic       yellowChange;
	logic       aicChange;
	logic       febeEvent;
	logic [7:0] febeLow;

	// Frame classification
	assign aisFrame = framingValid && cBitsZero && (xBits == ds3_rx_alarm_pkg::X_BITS_SET)
		&& payloadAlternating;
	assign idleFrame = framingValid && cpBitsZero && (xBits == ds3_rx_alarm_pkg::X_BITS_SET)
		&& payloadPairs;

	assign aisIf.frameTick  = frameDone;
	assign aisIf.hit        = aisFrame;
	assign idleIf.frameTick = frameDone;
	assign idleIf.hit       = idleFrame;

	alarm_updown_counter #(
		.THRESH (ds3_rx_alarm_pkg::ALARM_THRESH)
	) aisCounter (
		.clk     (clk),
		.sys_rst (sys_rst),
		.cnt     (aisIf.counter)
	);

	alarm_updown_counter #(
		.THRESH (ds3_rx_alarm_pkg::ALARM_THRESH)
	) idleCounter (
		.clk     (clk),
		.sys_rst (sys_rst),
		.cnt     (idleIf.counter)
	);

	// Bus request seen while waitrequest is still high
	assign busCap      = (read || write) && st_ff.waitReq;
	assign regIdx      = address[ds3_rx_alarm_pkg::ADDR_W-1:2];
	assign capIntRead  = busCap && read && (regIdx == ds3_rx_alarm_pkg::IDX_INT_FLAGS);
	assign capFebeRead = busCap && read && (regIdx == ds3_rx_alarm_pkg::IDX_FEBE_MSB);

	// Yellow alarm follows the X bits, holding on mixed values
	always_comb
	begin
		yellowNext = st_ff.yellow;
		if (frameDone && xBits == ds3_rx_alarm_pkg::X_BITS_CLEAR)
			yellowNext = 1'b1;
		else if (frameDone && xBits == ds3_rx_alarm_pkg::X_BITS_SET)
			yellowNext = 1'b0;
	end

	assign yellowChange = yellowNext != st_ff.yellow;
	assign aicChange    = frameDone && (rx_app_ident_bit != st_ff.aic);
	assign febeEvent    = frameDone && (rx_far_block_error_bits != ds3_rx_alarm_pkg::FEBE_CLEAN);
	assign febeLow      = st_ff.febeCount[7:0];

	// Register read value
	function automatic logic [7:0] readValue(
		input ds3_rx_alarm_pkg::rx_state_t s,
		input logic [7:0]                  idx,
		input logic                        aisDecl,
		input logic                        idleDecl
	);
		logic [7:0] v;
		v = 8'h00;
		if (idx == ds3_rx_alarm_pkg::IDX_CFG_STATUS)
		begin
			v[ds3_rx_alarm_pkg::CFG_AIS_BIT] = aisDecl;
			v[ds3_rx_alarm_pkg::CFG_IDLE_BIT] = idleDecl;
			v[ds3_rx_alarm_pkg::CFG_OPT_LSB +: ds3_rx_alarm_pkg::CFG_OPT_W] = s.cfgOpt;
		end
		else if (idx == ds3_rx_alarm_pkg::IDX_LINE_STATUS)
		begin
			v[ds3_rx_alarm_pkg::LINE_YELLOW_BIT] = s.yellow;
			v[ds3_rx_alarm_pkg::LINE_AIC_BIT] = s.aic;
			v[ds3_rx_alarm_pkg::LINE_FEBE_LSB +: 3] = s.febeRx;
		end
		else if (idx == ds3_rx_alarm_pkg::IDX_INT_FLAGS)
		begin
			v[ds3_rx_alarm_pkg::INT_AIS_BIT] = s.intAis;
			v[ds3_rx_alarm_pkg::INT_IDLE_BIT] = s.intIdle;
			v[ds3_rx_alarm_pkg::INT_FERF_BIT] = s.intFerf;
			v[ds3_rx_alarm_pkg::INT_AIC_BIT] = s.intAic;
		end
		else if (idx == ds3_rx_alarm_pkg::IDX_CONTROL)
			v[ds3_rx_alarm_pkg::CTRL_AUTO_FERF_BIT] = s.autoFerf;
		else if (idx == ds3_rx_alarm_pkg::IDX_FEBE_MSB)
			v = s.febeCount[15:8];
		else if (idx == ds3_rx_alarm_pkg::IDX_FEBE_LSB)
			v = s.febeLsbHold;
		return v;
	endfunction

	always_comb
	begin
		nxt_st = st_ff;

		// Bus handshake: waitrequest low for exactly one cycle per request
		nxt_st.waitReq = !busCap;
		if (busCap && read)
			nxt_st.rdData = {24'h000000, readValue(st_ff, regIdx, aisIf.declared, idleIf.declared)};
		if (busCap && write && byteenable[0])
		begin
			if (regIdx == ds3_rx_alarm_pkg::IDX_CFG_STATUS)
				nxt_st.cfgOpt = writedata[ds3_rx_alarm_pkg::CFG_OPT_LSB +: ds3_rx_alarm_pkg::CFG_OPT_W];
			else if (regIdx == ds3_rx_alarm_pkg::IDX_CONTROL)
				nxt_st.autoFerf = writedata[ds3_rx_alarm_pkg::CTRL_AUTO_FERF_BIT];
		end

		// Read side effects come first so that new events win
		if (capIntRead)
		begin
			nxt_st.intAis = 1'b0;
			nxt_st.intIdle = 1'b0;
			nxt_st.intFerf = 1'b0;
			nxt_st.intAic = 1'b0;
		end
		if (capFebeRead)
		begin
			nxt_st.febeLsbHold = st_ff.febeCount[7:0];
			nxt_st.febeCount = 16'h0000;
		end

		// Per-frame overhead
		if (frameDone)
		begin
			nxt_st.yellow = yellowNext;
			nxt_st.aic = rx_app_ident_bit;
			nxt_st.febeRx = rx_far_block_error_bits;
			if (parityErr || cpParityErr)
				nxt_st.txFebe = ds3_rx_alarm_pkg::FEBE_ERRORED;
			else
				nxt_st.txFebe = ds3_rx_alarm_pkg::FEBE_CLEAN;
		end
		if (febeEvent && nxt_st.febeCount != ds3_rx_alarm_pkg::FEBE_MAX)
			nxt_st.febeCount = nxt_st.febeCount + 16'h0001;

		// Change-of-status flags
		if (aisIf.changed)
			nxt_st.intAis = 1'b1;
		if (idleIf.changed)
			nxt_st.intIdle = 1'b1;
		if (yellowChange)
			nxt_st.intFerf = 1'b1;
		if (aicChange)
			nxt_st.intAic = 1'b1;
		nxt_st.intReq = nxt_st.intAis || nxt_st.intIdle || nxt_st.intFerf || nxt_st.intAic;

		// Alarm outputs
		nxt_st.aisPin = aisIf.declared;
		nxt_st.txFerf = aisIf.declared && st_ff.autoFerf;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_ff <= '0;
			st_ff.cfgOpt <= ds3_rx_alarm_pkg::CFG_OPT_RESET;
			st_ff.autoFerf <= ds3_rx_alarm_pkg::CTRL_AUTO_FERF_RESET;
			st_ff.txFebe <= ds3_rx_alarm_pkg::FEBE_CLEAN;
			st_ff.waitReq <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	assign readdata                 = st_ff.rdData;
	assign waitrequest              = st_ff.waitReq;
	assign rx_alarm_indication_flag = st_ff.aisPin;
	assign txFerfRequest            = st_ff.txFerf;
	assign txFebeBits               = st_ff.txFebe;
	assign intRequest               = st_ff.intReq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence busRequest;
		(read || write) && st_ff.waitReq;
	endsequence

	sequence busAnswer;
		!st_ff.waitReq ##1 st_ff.waitReq;
	endsequence

	sequence aisFlip;
		aisIf.changed;
	endsequence

	sequence aisReport;
		st_ff.intAis && st_ff.intReq;
	endsequence

	bus_answer_a: assert property (busRequest |=> busAnswer)
		else $error("waitrequest did not pulse low once");
	ais_pin_a: assert property (aisIf.declared |=> st_ff.aisPin)
		else $error("AIS pin not raised");
	ais_clear_a: assert property ($fell(aisIf.declared) |=> !st_ff.aisPin)
		else $error("AIS pin not dropped");
	ais_irq_a: assert property (aisFlip |=> aisReport)
		else $error("AIS change not flagged");
	ferf_force_a: assert property (aisIf.declared && st_ff.autoFerf |=> st_ff.txFerf)
		else $error("far-end failure not forced");
	yellow_set_a: assert property (frameDone && xBits == ds3_rx_alarm_pkg::X_BITS_CLEAR
		|=> st_ff.yellow && (st_ff.intFerf || $past(st_ff.yellow)))
		else $error("yellow alarm not declared");
	yellow_clear_a: assert property (frameDone && xBits == ds3_rx_alarm_pkg::X_BITS_SET
		|=> !st_ff.yellow)
		else $error("yellow alarm not cleared");
	febe_tx_a: assert property (frameDone && !parityErr && !cpParityErr
		|=> st_ff.txFebe == ds3_rx_alarm_pkg::FEBE_CLEAN)
		else $error("transmit FEBE not clean");
	febe_count_a: assert property (febeEvent && !capFebeRead
		&& st_ff.febeCount != ds3_rx_alarm_pkg::FEBE_MAX
		|=> st_ff.febeCount == $past(st_ff.febeCount) + 16'h0001)
		else $error("FEBE event not counted");
	aic_flag_a: assert property (aicChange |=> st_ff.intAic && st_ff.aic == $past(rx_app_ident_bit))
		else $error("AIC change not flagged");
	int_clear_a: assert property (capIntRead && !aisIf.changed |=> !st_ff.intAis)
		else $error("interrupt flag not cleared on read");

	sequence idleFlip;
		idleIf.changed;
	endsequence

	sequence idleReport;
		st_ff.intIdle && st_ff.intReq;
	endsequence

	sequence statusRead;
		busCap && read && regIdx == ds3_rx_alarm_pkg::IDX_CFG_STATUS;
	endsequence

	sequence lineRead;
		busCap && read && regIdx == ds3_rx_alarm_pkg::IDX_LINE_STATUS;
	endsequence

	idle_irq_a: assert property (idleFlip |=> idleReport)
		else $error("idle change not flagged");

	idle_clear_a: assert property (capIntRead && !idleIf.changed |=> !st_ff.intIdle)
		else $error("idle flag not cleared on read");

	yellow_irq_a: assert property (yellowChange |=> st_ff.intFerf && st_ff.intReq)
		else $error("yellow change not flagged");

	ais_status_a: assert property (statusRead
		|=> st_ff.rdData[ds3_rx_alarm_pkg::CFG_AIS_BIT] == $past(aisIf.declared))
		else $error("AIS status bit wrong");

	idle_status_a: assert property (statusRead
		|=> st_ff.rdData[ds3_rx_alarm_pkg::CFG_IDLE_BIT] == $past(idleIf.declared))
		else $error("idle status bit wrong");

	yellow_status_a: assert property (lineRead
		|=> st_ff.rdData[ds3_rx_alarm_pkg::LINE_YELLOW_BIT] == $past(st_ff.yellow))
		else $error("yellow status bit wrong");

	aic_status_a: assert property (frameDone |=> st_ff.aic == $past(rx_app_ident_bit))
		else $error("AIC status not updated");

	febe_bits_a: assert property (frameDone
		|=> st_ff.febeRx == $past(rx_far_block_error_bits))
		else $error("FEBE status bits not updated");

	febe_err_a: assert property (frameDone && (parityErr || cpParityErr)
		|=> st_ff.txFebe != ds3_rx_alarm_pkg::FEBE_CLEAN)
		else $error("transmit FEBE not marked errored");

	febe_quiet_a: assert property (frameDone && !capFebeRead
		&& rx_far_block_error_bits == ds3_rx_alarm_pkg::FEBE_CLEAN
		|=> st_ff.febeCount == $past(st_ff.febeCount))
		else $error("clean FEBE counted");

	febe_snap_a: assert property (capFebeRead && !febeEvent
		|=> st_ff.febeCount == 16'h0000 && st_ff.febeLsbHold == $past(febeLow))
		else $error("FEBE snapshot wrong");

	ferf_drop_a: assert property (!aisIf.declared |=> !st_ff.txFerf)
		else $error("far-end failure held without AIS");

	bus_idle_a: assert property (!read && !write && st_ff.waitReq |=> st_ff.waitReq)
		else $error("waitrequest dropped without request");
endmodule

/* dv/remote_frame_source.sv */
// Far-end terminal model: hands over per-M-frame overhead results.
// Assumes the bench calls send on the shared clock, after reset.
`timescale 1ns/100ps
module remote_frame_source (
	input  wire logic       clk,
	output logic            frameDone,
	output logic            framingValid,
	output logic            cBitsZero,
	output logic            cpBitsZero,
	output logic [1:0]      xBits,
	output logic            payloadAlternating,
	output logic            payloadPairs,
	output logic [2:0]      febeBits,
	output logic            aicBit,
	output logic            parityErr,
	output logic            cpParityErr
);
	logic [12:0] ohd;

	assign {framingValid, cBitsZero, cpBitsZero, xBits, payloadAlternating, payloadPairs,
		febeBits, aicBit, parityErr, cpParityErr} = ohd;

	initial
	begin
		frameDone = 1'b0;
		ohd = '0;
	end

	// Kind 1 AIS frame, kind 2 idle frame, kind 3 AIS payload with live C bits
	task automatic send(input int kind, input logic [1:0] x, input logic [2:0] fe,
		input logic aic, input logic pe, input logic cpe);
	begin
		@(posedge clk);
		frameDone <= 1'b1;
		ohd <= {1'b1, kind == 1, kind != 0, x, kind == 1 || kind == 3, kind == 2, fe, aic, pe,
			cpe};
		@(posedge clk);
		frameDone <= 1'b0;
		// Flags are meaningless between frames
		ohd <= ~ohd;
	end
	endtask
endmodule

/* dv/ds3_rx_alarm_detector_test.sv */
// Self-checking bench for the receive alarm detector.
// Assumes the frame source model and the design package are compiled first.
`timescale 1ns/100ps
module ds3_rx_alarm_detector_test;
	logic        clk;
	logic        sys_rst;
	logic        frameDone;
	logic        framingValid;
	logic        cBitsZero;
	logic        cpBitsZero;
	logic [1:0]  xBits;
	logic        payloadAlternating;
	logic        payloadPairs;
	logic [2:0]  febeIn;
	logic        aicIn;
	logic        parityErr;
	logic        cpParityErr;
	logic [9:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [3:0]  byteenable;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        aisPin;
	logic        txFerf;
	logic [2:0]  txFebe;
	logic        intReq;
	int          errors;
	int          num_checks;

	remote_frame_source u_remote_frame_source (.clk, .frameDone, .framingValid, .cBitsZero,
		.cpBitsZero, .xBits, .payloadAlternating, .payloadPairs, .febeBits(febeIn),
		.aicBit(aicIn), .parityErr, .cpParityErr);

	ds3_rx_alarm_detector u_ds3_rx_alarm_detector (.clk, .sys_rst, .frameDone, .framingValid,
		.cBitsZero, .cpBitsZero, .xBits, .payloadAlternating, .payloadPairs,
		.rx_far_block_error_bits(febeIn), .rx_app_ident_bit(aicIn), .parityErr, .cpParityErr,
		.address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
		.rx_alarm_indication_flag(aisPin), .txFerfRequest(txFerf), .txFebeBits(txFebe),
		.intRequest(intReq));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic complete_run;
	begin
		if (errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	task automatic check(input string name, input logic [31:0] expVal, input logic [31:0] got);
	begin
		num_checks++;
		if (got !== expVal)
		begin
			$display("[FAIL] %s expected %h seen %h", name, expVal, got);
			errors++;
		end
	end
	endtask

	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		input logic [3:0] be, output logic [31:0] rd);
		int n;
	begin
		@(posedge clk);
		address <= {idx, 2'b00};
		read <= !wr;
		write <= wr;
		writedata <= wd;
		byteenable <= be;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (waitrequest === 1'b0)
				break;
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n == 20)
		begin
			errors++;
			complete_run();
		end
	end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] v;
	begin
		bus(1'b1, idx, wd, be, v);
	end
	endtask

	task automatic rd(input string name, input logic [7:0] idx, input logic [31:0] expVal);
		logic [31:0] v;
	begin
		bus(1'b0, idx, 32'h0, 4'hF, v);
		check(name, expVal, v);
	end
	endtask

	// Sends a run of frames, then lets the declare path settle
	task automatic frames(input int kind, input int num);
	begin
		repeat (num) u_remote_frame_source.send(kind, 2'h3, 3'h7, 1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge clk);
	end
	endtask

	task automatic one(input logic [1:0] x, input logic [2:0] fe, input logic aic);
	begin
		u_remote_frame_source.send(0, x, fe, aic, 1'b0, 1'b0);
	end
	endtask

	initial
	begin
		sys_rst = 1'b1;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'hF;
		errors = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("txFebe reset", 32'h7, {29'h0, txFebe});
		check("pin reset", 32'h0, {31'h0, aisPin});
		rd("cfg reset", 8'h10, 32'h00);
		rd("flags reset", 8'h13, 32'h00);
		rd("control reset", 8'h20, 32'h01);
		wr(8'h10, 32'hFF, 4'hF);
		rd("cfg write", 8'h10, 32'h07);
		wr(8'h10, 32'h00, 4'h0);
		rd("cfg no byte", 8'h10, 32'h07);
		wr(8'h3F, 32'hFF, 4'hF);
		rd("unmapped", 8'h3F, 32'h00);
		// AIS declare at exactly 63 frames
		frames(1, 62);
		check("pin at 62", 32'h0, {31'h0, aisPin});
		frames(1, 1);
		check("pin at 63", 32'h1, {31'h0, aisPin});
		check("ferf tx", 32'h1, {31'h0, txFerf});
		check("int req", 32'h1, {31'h0, intReq});
		rd("cfg ais", 8'h10, 32'h87);
		rd("flags ais", 8'h13, 32'h20);
		rd("flags cleared", 8'h13, 32'h00);
		@(posedge clk);
		check("int req drop", 32'h0, {31'h0, intReq});
		wr(8'h20, 32'h00, 4'hF);
		@(posedge clk);
		check("ferf off", 32'h0, {31'h0, txFerf});
		wr(8'h20, 32'h01, 4'hF);
		// AIS clear only when the counter is back at zero
		frames(0, 62);
		check("pin held", 32'h1, {31'h0, aisPin});
		frames(0, 1);
		check("pin clear", 32'h0, {31'h0, aisPin});
		check("ferf clear", 32'h0, {31'h0, txFerf});
		rd("cfg clear", 8'h10, 32'h07);
		rd("flags clear", 8'h13, 32'h20);
		// Idle frames also count as non-AIS frames at the floor
		frames(2, 62);
		rd("idle at 62", 8'h10, 32'h07);
		frames(2, 1);
		rd("idle at 63", 8'h10, 32'h27);
		rd("flags idle", 8'h13, 32'h10);
		frames(1, 62);
		rd("idle held", 8'h10, 32'h27);
		frames(0, 1);
		rd("idle clear", 8'h10, 32'h07);
		rd("flags idle clr", 8'h13, 32'h10);
		// Yellow alarm: set, hold on mixed X bits, clear
		one(2'h0, 3'h7, 1'b0);
		rd("yellow on", 8'h11, 32'h17);
		rd("flags yellow", 8'h13, 32'h08);
		one(2'h1, 3'h7, 1'b0);
		rd("yellow held", 8'h11, 32'h17);
		one(2'h3, 3'h7, 1'b0);
		rd("yellow off", 8'h11, 32'h07);
		rd("flags yel clr", 8'h13, 32'h08);
		// Application identification bit
		one(2'h3, 3'h7, 1'b1);
		rd("aic one", 8'h11, 32'h0F);
		rd("flags aic", 8'h13, 32'h04);
		one(2'h3, 3'h7, 1'b0);
		rd("flags aic back", 8'h13, 32'h04);
		// Far-end block error events, read high then low
		repeat (3) one(2'h3, 3'h5, 1'b0);
		rd("febe bits", 8'h11, 32'h05);
		rd("febe high", 8'h58, 32'h00);
		rd("febe low", 8'h59, 32'h03);
		rd("febe high 2", 8'h58, 32'h00);
		rd("febe low 2", 8'h59, 32'h00);
		// Transmit FEBE follows parity results
		for (int k = 0; k < 4; k++)
		begin
			u_remote_frame_source.send(0, 2'h3, 3'h7, 1'b0, k == 1, k == 3);
			@(posedge clk);
			check("tx febe", (k % 2) ? 32'h0 : 32'h7, {29'h0, txFebe});
		end
		// Mid-run reset clears a declared AIS and its counter
		frames(1, 62);
		check("pin before rst", 32'h1, {31'h0, aisPin});
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check("pin after rst", 32'h0, {31'h0, aisPin});
		frames(1, 62);
		check("pin 62 after rst", 32'h0, {31'h0, aisPin});
		frames(1, 1);
		check("pin 63 after rst", 32'h1, {31'h0, aisPin});
		// Alternating payload with nonzero C bits is not an AIS frame
		frames(3, 63);
		check("pin live C", 32'h0, {31'h0, aisPin});
		complete_run();
	end
endmodule
